/* shared/matrix_defs.svh */
`ifndef MATRIX_DEFS_SVH
`define MATRIX_DEFS_SVH

`define CLK_HZ 50000000
`define ROWS 8
`define COLS_UNIT 72
`define COLS_CHAIN 360
`define SETUP_WORDS 5'd18
`define SETUP_SUM_WORD 5'd18
`define SETUP_LAST_WORD 5'd17
`define SETUP_COUNT 7'd100
`define SETUP_FIRST 7'd1
`define RATE_PER_S 200
`define PM_LAST 12'hFFF
`define SCRATCH_BASE 12'hFE0
`define SCRATCH_LAST 12'd3
`define CFG_ADDR 12'hFFF
`define CFG_MASTER 8
`define SLOT_LAST 3'd5
`define ID_SUM_BYTE 2'd3
`define RAM_PATTERN 32'hA5A5_5A5A
`define LAMP_MS 500
`define SHOW_MS 1000

`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_SEL 8'h08
`define REG_DATA 8'h0C
`define REG_STATUS 8'h10
`define REG_IRQ_STAT 8'h14
`define REG_IRQ_MASK 8'h18
`define REG_STEPS 8'h1C
`define REG_REV 8'h20

`define CTRL_AUTO 0
`define CTRL_TRIG 1
`define CTRL_LIVE 2
`define CMD_OP_LO 8
`define OP_MEM_TO_RELAY 2'd1
`define OP_RELAY_TO_MEM 2'd2

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* shared/matrix_pkg.sv */
package matrix_pkg;

  typedef enum logic [4:0] {
    S_PM = 5'b00000,
    S_RAM_WR = 5'b00001,
    S_RAM_RD = 5'b00010,
    S_MEM_RPT = 5'b00011,
    S_CARD = 5'b00100,
    S_CARD_WAIT = 5'b00101,
    S_SETUP = 5'b00110,
    S_SETUP_CLR = 5'b00111,
    S_SETUP_WAIT = 5'b01000,
    S_LAYOUT = 5'b01001,
    S_REFORMAT = 5'b01010,
    S_LINK = 5'b01011,
    S_LINK_WAIT = 5'b01100,
    S_LINK_ERR = 5'b01101,
    S_LAMP = 5'b01110,
    S_REV = 5'b01111,
    S_OPEN = 5'b10000,
    S_RUN = 5'b10001,
    S_COPY = 5'b10010
  } state_t;

  typedef enum logic [2:0] {
    MSG_NONE = 3'b000,
    MSG_PROG_FAIL = 3'b001,
    MSG_WORK_FAIL = 3'b010,
    MSG_CARD = 3'b011,
    MSG_SETUP = 3'b100,
    MSG_LINK = 3'b101,
    MSG_REV = 3'b110
  } msg_t;

endpackage

/* rtl/matrix_ctrl.sv */
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "matrix_defs.svh"
// Function
// - Hold 8x72 setups per unit, 360 chained
// - Relay transfer fast enough for 200/s
// - Memory-to-relay on bus command or trigger
// - Automatic mode copies recalled setup to relays
// - Memory view refreshes on bus change
// - Live view refreshes on relay change
// - Controller changes to shown setup appear; here bus and trigger updates skip the display while panel_edit is high
// - Program sum, work test, report after
// - Keypress overrides memory failure, continue
// - Card identity checksum, light card, wait key
// - Empty slot raises no identity error
// - Bad setup cleared, message until key
// - Layout change reformats all setups, display blank
// - Master probes loop, others stand alone
// - Open loop: error, then stand alone
// - Lamp test, then revision and address
// - First five stages silent unless error
// - Finish: relays open, live view, steps
module matrix_ctrl
  import matrix_pkg::*;
#(
  parameter logic [11:0] FW_REV = 12'h123, // Arbitrary value
  parameter int LAMP_CYCLES = `LAMP_MS * (`CLK_HZ / 1000),
  parameter int SHOW_CYCLES = `SHOW_MS * (`CLK_HZ / 1000)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  input wire logic key_press,
  input wire logic trigger,
  input wire logic panel_recall,
  input wire logic [6:0] panel_index,
  input wire logic panel_edit,
  input wire logic [5:0] card_present,
  input wire logic [4:0] bus_addr,
  input wire logic loop_done,
  input wire logic loop_closed,
  output logic [11:0] pm_addr,
  input wire logic [31:0] pm_rdata,
  output logic [11:0] sm_addr,
  output logic [31:0] sm_wdata,
  output logic sm_we,
  input wire logic [31:0] sm_rdata,
  output logic [2:0] card_slot,
  output logic [1:0] card_byte,
  input wire logic [7:0] card_rdata,
  output logic [4:0] relay_addr,
  output logic [31:0] relay_wdata,
  output logic relay_we,
  output logic [4:0] disp_addr,
  output logic [31:0] disp_wdata,
  output logic disp_we,
  output logic disp_blank,
  output logic lamp_test,
  output logic [5:0] card_fill,
  output msg_t msg,
  output logic [11:0] rev_code,
  output logic [4:0] show_addr,
  output logic master_role
);

  function automatic logic [11:0] saddr(input logic [6:0] i, input logic [4:0] w);
    saddr = {i, w};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction

  state_t state;
  logic [11:0] addr;
  logic ph;
  logic [31:0] acc;
  logic [6:0] idx;
  logic [4:0] word;
  logic [31:0] timer;
  logic [31:0] cfg_word;
  logic prog_bad, work_bad, card_bad, setup_bad, link_bad;
  logic [31:0] relay_shadow [0:17];
  logic [6:0] relay_step, memory_step;
  logic cp_src_mem, cp_to_relay, cp_to_disp, cp_to_mem;
  logic [6:0] cp_idx;
  logic [5:0] ev;
  logic boot_done, cmd_take, ctl_take;

  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, rd_fire, bus_op, wr_ok, rd_ok;
  logic auto_mode, trig_en, view_live;
  logic cmd_pend, ctl_pend;
  logic [1:0] cmd_op;
  logic [6:0] cmd_idx;
  logic [4:0] ctl_sel;
  logic [31:0] ctl_data;
  logic [5:0] irq_stat, irq_mask;
  logic [31:0] next_rdata;
  logic [6:0] trig_idx;
  logic [31:0] cp_data;
  logic refresh_ok;

  assign pm_addr = addr;
  assign card_byte = addr[1:0];
  assign rev_code = FW_REV;
  assign show_addr = bus_addr;
  assign trig_idx = (relay_step >= `SETUP_COUNT) ? `SETUP_FIRST : relay_step + 7'd1;
  assign cp_data = cp_src_mem ? sm_rdata : relay_shadow[word];
  assign refresh_ok = !panel_edit;

  // Power-up sequencer and setup copy engine share the memory port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_PM;
      addr <= 12'h000;
      ph <= 1'b0;
      acc <= 32'h0000_0000;
      idx <= 7'h00;
      word <= 5'h00;
      timer <= 32'h0000_0000;
      cfg_word <= 32'h0000_0000;
      {prog_bad, work_bad, card_bad, setup_bad, link_bad} <= 5'h00;
      relay_step <= 7'h00;
      memory_step <= 7'h01;
      {cp_src_mem, cp_to_relay, cp_to_disp, cp_to_mem} <= 4'h0;
      cp_idx <= 7'h00;
      ev <= 6'h00;
      {boot_done, cmd_take, ctl_take} <= 3'h0;
      sm_addr <= 12'h000;
      sm_wdata <= 32'h0000_0000;
      sm_we <= 1'b0;
      card_slot <= 3'h0;
      relay_addr <= 5'h00;
      relay_wdata <= 32'h0000_0000;
      relay_we <= 1'b0;
      disp_addr <= 5'h00;
      disp_wdata <= 32'h0000_0000;
      disp_we <= 1'b0;
      disp_blank <= 1'b1;
      lamp_test <= 1'b0;
      card_fill <= 6'h00;
      msg <= MSG_NONE;
      master_role <= 1'b0;
      for (int i = 0; i < 18; i++) begin
        relay_shadow[i] <= 32'h0000_0000;
      end
    end else begin
      sm_we <= 1'b0;
      relay_we <= 1'b0;
      disp_we <= 1'b0;
      ev <= 6'h00;
      {boot_done, cmd_take, ctl_take} <= 3'h0;
      case (state)
        S_PM: begin
          ph <= !ph;
          if (ph) begin
            if (addr == `PM_LAST) begin
              prog_bad <= (acc != pm_rdata);
              addr <= 12'h000;
              state <= S_RAM_WR;
            end else begin
              acc <= acc + pm_rdata;
              addr <= addr + 12'd1;
            end
          end
        end
        S_RAM_WR: begin
          sm_we <= 1'b1;
          sm_addr <= `SCRATCH_BASE + addr;
          sm_wdata <= `RAM_PATTERN ^ {20'h00000, addr};
          addr <= (addr == `SCRATCH_LAST) ? 12'h000 : addr + 12'd1;
          if (addr == `SCRATCH_LAST) begin
            state <= S_RAM_RD;
          end
        end
        S_RAM_RD: begin
          ph <= !ph;
          sm_addr <= `SCRATCH_BASE + addr;
          if (ph) begin
            if (sm_rdata != (`RAM_PATTERN ^ {20'h00000, addr})) begin
              work_bad <= 1'b1;
            end
            addr <= addr + 12'd1;
            if (addr == `SCRATCH_LAST) begin
              state <= S_MEM_RPT;
            end
          end
        end
        S_MEM_RPT: begin
          if (prog_bad || work_bad) begin
            msg <= prog_bad ? MSG_PROG_FAIL : MSG_WORK_FAIL;
            if (msg == MSG_NONE) begin
              ev[1] <= 1'b1;
            end
          end
          if (!(prog_bad || work_bad) || (msg != MSG_NONE && key_press)) begin
            msg <= MSG_NONE;
            addr <= 12'h000;
            card_slot <= 3'h0;
            acc <= 32'h0000_0000;
            state <= S_CARD;
          end
        end
        S_CARD: begin
          if (!card_present[card_slot] || (ph && addr[1:0] == `ID_SUM_BYTE)) begin
            if (card_present[card_slot] && acc[7:0] != card_rdata) begin
              card_bad <= 1'b1;
              card_fill[card_slot] <= 1'b1;
            end
            ph <= 1'b0;
            addr <= 12'h000;
            acc <= 32'h0000_0000;
            card_slot <= card_slot + 3'd1;
            if (card_slot == `SLOT_LAST) begin
              state <= S_CARD_WAIT;
            end
          end else begin
            ph <= !ph;
            if (ph) begin
              acc <= acc + {24'h000000, card_rdata};
              addr <= addr + 12'd1;
            end
          end
        end
        S_CARD_WAIT: begin
          if (card_bad && msg == MSG_NONE) begin
            msg <= MSG_CARD;
            ev[2] <= 1'b1;
          end else if (!card_bad || key_press) begin
            msg <= MSG_NONE;
            card_fill <= 6'h00;
            idx <= `SETUP_FIRST;
            word <= 5'h00;
            acc <= 32'h0000_0000;
            state <= S_SETUP;
          end
        end
        S_SETUP: begin
          ph <= !ph;
          sm_addr <= saddr(idx, word);
          if (ph) begin
            acc <= acc + sm_rdata;
            word <= word + 5'd1;
            if (word == `SETUP_SUM_WORD) begin
              word <= 5'h00;
              acc <= 32'h0000_0000;
              if (acc != sm_rdata) begin
                setup_bad <= 1'b1;
                state <= S_SETUP_CLR;
              end else if (idx == `SETUP_COUNT) begin
                state <= S_SETUP_WAIT;
              end else begin
                idx <= idx + 7'd1;
              end
            end
          end
        end
        S_SETUP_CLR: begin
          sm_we <= 1'b1;
          sm_addr <= saddr(idx, word);
          sm_wdata <= 32'h0000_0000;
          word <= word + 5'd1;
          if (word == `SETUP_SUM_WORD) begin
            word <= 5'h00;
            idx <= idx + 7'd1;
            state <= (idx == `SETUP_COUNT) ? S_SETUP_WAIT : S_SETUP;
          end
        end
        S_SETUP_WAIT: begin
          if (setup_bad && msg == MSG_NONE) begin
            msg <= MSG_SETUP;
            ev[3] <= 1'b1;
          end else if (!setup_bad || key_press) begin
            msg <= MSG_NONE;
            sm_addr <= `CFG_ADDR;
            ph <= 1'b0;
            state <= S_LAYOUT;
          end
        end
        S_LAYOUT: begin
          ph <= 1'b1;
          if (ph) begin
            cfg_word <= sm_rdata;
            idx <= `SETUP_FIRST;
            word <= 5'h00;
            ph <= 1'b0;
            acc <= 32'h0000_0000;
            state <= (sm_rdata[5:0] != card_present) ? S_REFORMAT : S_LINK;
          end
        end
        S_REFORMAT: begin
          // Data words kept, each setup resealed
          if (word == `SETUP_WORDS) begin
            sm_we <= 1'b1;
            sm_addr <= saddr(idx, word);
            sm_wdata <= acc;
            word <= 5'h00;
            acc <= 32'h0000_0000;
            idx <= idx + 7'd1;
            if (idx == `SETUP_COUNT) begin
              idx <= 7'h7F;
              word <= 5'h1F;
            end
          end else if (idx == 7'h7F) begin
            sm_we <= 1'b1;
            sm_addr <= `CFG_ADDR;
            sm_wdata <= {cfg_word[31:6], card_present};
            state <= S_LINK;
          end else begin
            ph <= !ph;
            sm_addr <= saddr(idx, word);
            if (ph) begin
              acc <= acc + sm_rdata;
              word <= word + 5'd1;
            end
          end
        end
        S_LINK: begin
          disp_blank <= 1'b1;
          if (cfg_word[`CFG_MASTER]) begin
            state <= S_LINK_WAIT;
          end else begin
            master_role <= 1'b0;
            state <= S_LAMP;
          end
        end
        S_LINK_WAIT: begin
          if (loop_done) begin
            master_role <= loop_closed;
            link_bad <= !loop_closed;
            state <= loop_closed ? S_LAMP : S_LINK_ERR;
            msg <= loop_closed ? MSG_NONE : MSG_LINK;
            ev[4] <= !loop_closed;
          end
        end
        S_LINK_ERR: begin
          if (key_press || bus_op) begin
            msg <= MSG_NONE;
            state <= S_LAMP;
          end
        end
        S_LAMP: begin
          disp_blank <= 1'b0;
          lamp_test <= 1'b1;
          timer <= timer + 32'd1;
          if (timer == LAMP_CYCLES - 1) begin
            lamp_test <= 1'b0;
            timer <= 32'h0000_0000;
            msg <= MSG_REV;
            state <= S_REV;
          end
        end
        S_REV: begin
          timer <= timer + 32'd1;
          if (timer == SHOW_CYCLES - 1) begin
            msg <= MSG_NONE;
            word <= 5'h00;
            state <= S_OPEN;
          end
        end
        S_OPEN: begin
          relay_we <= 1'b1;
          relay_addr <= word;
          relay_wdata <= 32'h0000_0000;
          relay_shadow[word] <= 32'h0000_0000;
          disp_we <= 1'b1;
          disp_addr <= word;
          disp_wdata <= 32'h0000_0000;
          word <= word + 5'd1;
          if (word == `SETUP_LAST_WORD) begin
            relay_step <= 7'h00;
            memory_step <= 7'h01;
            boot_done <= 1'b1;
            ev[0] <= 1'b1;
            state <= S_RUN;
          end
        end
        S_RUN: begin
          word <= 5'h00;
          ph <= 1'b0;
          acc <= 32'h0000_0000;
          if (cmd_pend) begin
            cmd_take <= 1'b1;
            cp_idx <= cmd_idx;
            cp_src_mem <= (cmd_op == `OP_MEM_TO_RELAY);
            cp_to_relay <= (cmd_op == `OP_MEM_TO_RELAY);
            cp_to_mem <= (cmd_op == `OP_RELAY_TO_MEM);
            cp_to_disp <= refresh_ok && ((cmd_op == `OP_MEM_TO_RELAY && view_live) ||
                          (cmd_op == `OP_RELAY_TO_MEM && !view_live &&
                           cmd_idx == memory_step));
            if (cmd_op == `OP_MEM_TO_RELAY) begin
              relay_step <= cmd_idx;
            end
            state <= S_COPY;
          end else if (trigger && trig_en) begin
            cp_idx <= trig_idx;
            relay_step <= trig_idx;
            {cp_src_mem, cp_to_relay, cp_to_mem} <= 3'b110;
            cp_to_disp <= view_live && refresh_ok;
            state <= S_COPY;
          end else if (ctl_pend) begin
            ctl_take <= 1'b1;
            relay_we <= 1'b1;
            relay_addr <= ctl_sel;
            relay_wdata <= ctl_data;
            relay_shadow[ctl_sel] <= ctl_data;
            disp_we <= view_live && refresh_ok;
            disp_addr <= ctl_sel;
            disp_wdata <= ctl_data;
          end else if (panel_recall) begin
            cp_idx <= panel_index;
            memory_step <= panel_index;
            {cp_src_mem, cp_to_disp, cp_to_mem} <= 3'b110;
            cp_to_relay <= auto_mode;
            if (auto_mode) begin
              relay_step <= panel_index;
            end
            state <= S_COPY;
          end
        end
        S_COPY: begin
          // Two cycles a word, well inside the 200 setups/s budget
          ph <= !ph;
          sm_addr <= saddr(cp_idx, word);
          if (word == `SETUP_SUM_WORD) begin
            sm_we <= cp_to_mem;
            sm_wdata <= acc;
            ev[5] <= 1'b1;
            state <= S_RUN;
          end else if (ph) begin
            acc <= acc + cp_data;
            word <= word + 5'd1;
            relay_we <= cp_to_relay;
            relay_addr <= word;
            relay_wdata <= cp_data;
            if (cp_to_relay) begin
              relay_shadow[word] <= cp_data;
            end
            disp_we <= cp_to_disp;
            disp_addr <= word;
            disp_wdata <= cp_data;
            sm_we <= cp_to_mem;
            sm_wdata <= cp_data;
          end
        end
        default: state <= S_PM;
      endcase
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign arready = !rvalid;
  assign rd_fire = arvalid && !rvalid;
  assign bus_op = wr_fire || rd_fire;
  assign wr_ok = aw_addr <= `REG_REV && aw_addr[1:0] == 2'b00;
  assign rd_ok = araddr <= `REG_REV && araddr[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_held, w_held, bvalid} <= 3'h0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        {aw_held, w_held, bvalid} <= 3'b001;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (araddr == `REG_CTRL) begin
      next_rdata = {29'h0, view_live, trig_en, auto_mode};
    end else if (araddr == `REG_CMD) begin
      next_rdata = {22'h0, cmd_op, 1'b0, cmd_idx};
    end else if (araddr == `REG_SEL) begin
      next_rdata = {27'h0, ctl_sel};
    end else if (araddr == `REG_DATA) begin
      next_rdata = ctl_data;
    end else if (araddr == `REG_STATUS) begin
      next_rdata = {16'h0, cmd_pend | ctl_pend, master_role, link_bad, setup_bad,
                    card_bad, work_bad, prog_bad, 1'b0, 3'h0, state};
    end else if (araddr == `REG_IRQ_STAT) begin
      next_rdata = {26'h0, irq_stat};
    end else if (araddr == `REG_IRQ_MASK) begin
      next_rdata = {26'h0, irq_mask};
    end else if (araddr == `REG_STEPS) begin
      next_rdata = {17'h0, memory_step, 1'b0, relay_step};
    end else if (araddr == `REG_REV) begin
      next_rdata = {15'h0, bus_addr, FW_REV};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Software-visible control; CMD and DATA writes while their request is pending are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {auto_mode, trig_en, view_live, cmd_pend, ctl_pend} <= 5'b00100;
      cmd_op <= 2'h0;
      cmd_idx <= 7'h00;
      ctl_sel <= 5'h00;
      ctl_data <= 32'h0000_0000;
      irq_mask <= 6'h00;
    end else begin
      if (boot_done) begin
        trig_en <= 1'b0;
        view_live <= 1'b1;
      end else if (wr_fire && aw_addr == `REG_CTRL && w_strb[0]) begin
        {view_live, trig_en, auto_mode} <= w_data[2:0];
      end
      if (cmd_take) begin
        cmd_pend <= 1'b0;
      end else if (wr_fire && aw_addr == `REG_CMD && !cmd_pend) begin
        cmd_pend <= 1'b1;
        cmd_op <= w_data[`CMD_OP_LO +: 2];
        cmd_idx <= w_data[6:0];
      end
      if (ctl_take) begin
        ctl_pend <= 1'b0;
      end else if (wr_fire && aw_addr == `REG_DATA && !ctl_pend) begin
        ctl_pend <= 1'b1;
        ctl_data <= merge(ctl_data, w_data, w_strb);
      end
      if (wr_fire && aw_addr == `REG_SEL && w_strb[0] && w_data[4:0] <= `SETUP_LAST_WORD) begin
        ctl_sel <= w_data[4:0];
      end
      if (wr_fire && aw_addr == `REG_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[5:0];
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 6'h00;
    end else if (wr_fire && aw_addr == `REG_IRQ_STAT && w_strb[0]) begin
      irq_stat <= (irq_stat & ~w_data[5:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule

/* dv/matrix_ctrl_props.sv */
`timescale 1ns/10ps
module matrix_ctrl_props
  import matrix_pkg::*;
#(
  parameter logic [11:0] FW_REV = 12'h123
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic key_press,
  input wire logic [4:0] bus_addr,
  input wire logic disp_we,
  input wire logic disp_blank,
  input wire logic lamp_test,
  input wire logic [5:0] card_fill,
  input wire msg_t msg,
  input wire logic [11:0] rev_code,
  input wire logic [4:0] show_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence lamp_run;
    lamp_test [*7];
  endsequence
  chk_ar_gate: assert property (arready == !rvalid)
    else $error("read address ready while data held");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("no read data after address");
  chk_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("no write response");
  chk_mem_wait: assert property (msg inside {MSG_PROG_FAIL, MSG_WORK_FAIL} && !key_press |=> msg == $past(msg))
    else $error("memory report left without key");
  chk_card_lit: assert property (msg == MSG_CARD && $stable(msg) |-> card_fill != 6'h00)
    else $error("faulty card not lit");
  chk_lamp_len: assert property ($rose(lamp_test) |-> lamp_run)
    else $error("lamp test too short");
  chk_rev_show: assert property (msg == MSG_REV |-> rev_code == FW_REV && show_addr == bus_addr)
    else $error("revision or address wrong");
  chk_quiet_stage: assert property (disp_blank |-> !disp_we && !lamp_test)
    else $error("output during silent stages");
endmodule

bind matrix_ctrl matrix_ctrl_props #(.FW_REV(FW_REV)) props_inst (.*);

/* dv/matrix_far_side.sv */
`timescale 1ns/10ps
module matrix_far_side (
  input wire logic aclk,
  input wire logic [11:0] pm_addr,
  output logic [31:0] pm_rdata,
  input wire logic [11:0] sm_addr,
  input wire logic [31:0] sm_wdata,
  input wire logic sm_we,
  output logic [31:0] sm_rdata,
  input wire logic [2:0] card_slot,
  input wire logic [1:0] card_byte,
  output logic [7:0] card_rdata
);
  logic [31:0] sm [0:4095];
  // Bad program sum, bad slot 1 identity sum
  assign pm_rdata = (pm_addr == 12'hFFF) ? 32'h0000_0001 : 32'h0000_0000;
  assign card_rdata = (card_slot == 3'h1 && card_byte == 2'h3) ? 8'h5A : 8'h00;
  assign sm_rdata = sm[sm_addr];
  initial begin
    for (int i = 0; i < 4096; i++) sm[i] = 32'h0;
    sm[12'h0A0] = 32'h0000_0001; // Setup 5 with broken sum
    sm[12'hFFF] = 32'h0000_0103; // Master, layout of slots 0 and 1
  end
  always @(posedge aclk) begin
    if (sm_we) sm[sm_addr] <= sm_wdata;
  end
endmodule

/* dv/testbench.sv */
`timescale 1ns/10ps
`include "matrix_defs.svh"
module testbench;
  import matrix_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic key_press = 0, trigger = 0, panel_recall = 0, panel_edit = 0, loop_closed = 0;
  logic [6:0] panel_index = 7'h00;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, card_rdata;
  logic [31:0] wdata = 32'h0, rdata, pm_rdata, sm_wdata, sm_rdata, relay_wdata, disp_wdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, sm_we, relay_we, disp_we;
  logic disp_blank, lamp_test, master_role;
  logic [1:0] bresp, rresp, card_byte, resp;
  logic [11:0] pm_addr, sm_addr, rev_code;
  logic [2:0] card_slot;
  logic [4:0] relay_addr, disp_addr, show_addr;
  logic [5:0] card_fill;
  msg_t msg;
  int failures = 0, cmp_count = 0, cyc = 0, n_rel = 0, n_disp = 0;
  matrix_ctrl #(.LAMP_CYCLES(8), .SHOW_CYCLES(8)) matrix_ctrl_inst (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .key_press, .trigger,
    .panel_recall, .panel_index, .panel_edit, .card_present(6'h03), .bus_addr(5'h12),
    .loop_done(1'h1), .loop_closed, .pm_addr, .pm_rdata, .sm_addr, .sm_wdata, .sm_we,
    .sm_rdata, .card_slot, .card_byte, .card_rdata, .relay_addr, .relay_wdata, .relay_we,
    .disp_addr, .disp_wdata, .disp_we, .disp_blank, .lamp_test, .card_fill, .msg, .rev_code,
    .show_addr, .master_role);
  matrix_far_side matrix_far_side_inst (.aclk, .pm_addr, .pm_rdata, .sm_addr, .sm_wdata,
    .sm_we, .sm_rdata, .card_slot, .card_byte, .card_rdata);
  always #10 aclk = ~aclk;
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (relay_we) n_rel++;
    if (disp_we) n_disp++;
    if (cyc == 60000) begin
      failures++;
      close_out();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  task key();
    @(posedge aclk);
    key_press <= 1'h1;
    @(posedge aclk);
    key_press <= 1'h0;
  endtask
  task wait_msg(input msg_t m);
    do @(negedge aclk); while (msg !== m);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    wait_msg(MSG_PROG_FAIL);
    key();
    wait_msg(MSG_CARD);
    chk("card_fill", 32'h2, {26'h0, card_fill});
    key();
    wait_msg(MSG_SETUP);
    key();
    wait_msg(MSG_LINK);
    key();
    wait_msg(MSG_REV);
    do rd(`REG_STATUS); while (d[4:0] !== S_RUN);
    $display("test boot done");
    chk("bad setup word", 32'h0, matrix_far_side_inst.sm[12'h0A0]);
    chk("master_role", 32'h0, {31'h0, master_role});
    rd(`REG_STEPS);
    chk("steps", 32'h100, d);
    rd(`REG_CTRL);
    chk("ctrl", 32'h4, d);
    rd(`REG_REV);
    chk("rev", 32'h12123, d);
    rd(8'h40);
    chk("unmapped resp", 32'h2, {30'h0, resp});
    $display("test registers done");
    wr(`REG_IRQ_MASK, 32'h20);
    wr(`REG_CTRL, 32'h6);
    @(posedge aclk);
    trigger <= 1'h1;
    @(posedge aclk);
    trigger <= 1'h0;
    do @(negedge aclk); while (!irq);
    chk("relay words", 32'd36, n_rel);
    chk("live refresh", 32'd36, n_disp);
    rd(`REG_STEPS);
    chk("steps", 32'h101, d);
    wr(`REG_IRQ_STAT, 32'h20);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test trigger done");
    panel_edit <= 1'h1;
    wr(`REG_CMD, 32'h103);
    do @(negedge aclk); while (!irq);
    chk("relay words", 32'd54, n_rel);
    chk("live refresh", 32'd36, n_disp);
    $display("test bus copy done");
    wr(`REG_CTRL, 32'h1);
    @(posedge aclk);
    panel_recall <= 1'h1;
    panel_index <= 7'h02;
    @(posedge aclk);
    panel_recall <= 1'h0;
    while (n_rel < 72) @(negedge aclk);
    do rd(`REG_STATUS); while (d[15] !== 1'h0);
    chk("recall display", 32'd54, n_disp);
    $display("test recall done");
    close_out();
  end
endmodule
